// ===== common/smr_pkg.sv
// Summary of operation
// - A current read takes its low byte from the latched address, one past the last access.
// - Read start address joins three page bits with the eight latched low bits.
// - First read bit is driven on the clock right after the address acknowledge.
// - Reads run for any number of bytes; address counter steps after each byte.
// - A master acknowledge makes the device send the next sequential byte.
// - After address 7FFh the next read access wraps to 000h.
// - Without a valid end the device keeps driving further read data.
// - Write address byte plus word address byte loads the address latch.
// - START after word address acknowledge aborts the write; read then continues there.
// - Every read access fetches one whole 64-bit row; rows start on 8-byte boundaries.
// - A missing master acknowledge ends the read and releases the data line.
// - Data bytes leave most significant bit first.
// - The address latch steps after each byte, just before the acknowledge slot.
// - STOP or START during an operation aborts it and readies the device.
package smr_pkg;

  localparam int ADDR_W        = 11;
  localparam int ROW_W         = 64;
  localparam int ROW_IDX_W     = 8;
  localparam int BYTE_SEL_W    = 3;
  localparam int PAGE_W        = 3;

  localparam logic [3:0]  DEV_TYPE      = 4'hA;
  localparam logic [3:0]  BITS_LAST     = 4'h8;
  localparam logic [3:0]  SEND_LAST     = 4'h7;
  localparam logic [10:0] ADDR_RESET    = 11'h000;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [3:0]  CNT_RESET     = 4'h0;

  typedef enum logic [3:0] {
    SMR_IDLE,
    SMR_ADDR,
    SMR_ADDR_ACK,
    SMR_WADDR,
    SMR_WADDR_ACK,
    SMR_IGNORE,
    SMR_SEND,
    SMR_SEND_ACK
  } smr_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } smr_line_t;

  localparam smr_line_t LINE_IDLE = '{scl: 1'b1, sda: 1'b1};

endpackage : smr_pkg

// ===== logic/smr_read_path.sv
`timescale 1ns/100ps
module smr_read_path (
  input  wire logic                          ref_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          clkEn,
  input  wire logic                          sclIn,
  input  wire logic                          sdaIn,
  output logic                               sdaOut,
  output logic                               sdaOe,
  output logic                               rowRdReq,
  output logic [smr_pkg::ROW_IDX_W-1:0]      rowIdx,
  input  wire logic [smr_pkg::ROW_W-1:0]     rowData,
  output logic                               busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus events

  smr_pkg::smr_line_t syncA_reg;
  smr_pkg::smr_line_t syncB_reg;
  smr_pkg::smr_line_t prev_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      syncA_reg <= smr_pkg::LINE_IDLE;
      syncB_reg <= smr_pkg::LINE_IDLE;
      prev_reg  <= smr_pkg::LINE_IDLE;
    end else if (clkEn) begin
      syncA_reg <= '{scl: sclIn, sda: sdaIn};
      syncB_reg <= syncA_reg;
      prev_reg  <= syncB_reg;
    end
  end

  wire logic sclRise = syncB_reg.scl & ~prev_reg.scl;
  wire logic sclFall = ~syncB_reg.scl & prev_reg.scl;
  wire logic sclHigh = syncB_reg.scl & prev_reg.scl;
  wire logic startEv = sclHigh & prev_reg.sda & ~syncB_reg.sda;
  wire logic stopEv  = sclHigh & ~prev_reg.sda & syncB_reg.sda;

  ////////////////////////////////////////////////////////////////////////////
  // Control state

  smr_pkg::smr_state_t          state_reg;
  logic [3:0]                   bitCnt_reg;
  logic [7:0]                   shiftIn_reg;
  logic [7:0]                   shiftOut_reg;
  logic [7:0]                   byte_reg;
  logic [smr_pkg::ADDR_W-1:0]   addr_reg;
  logic                         drvLow_reg;
  logic                         ackSeen_reg;
  logic                         fetch_reg;
  logic                         fetchDly_reg;
  logic [smr_pkg::BYTE_SEL_W-1:0] fetchSel_reg;

  wire logic [7:0] nextIn    = {shiftIn_reg[6:0], syncB_reg.sda};
  wire logic       addrMatch = (shiftIn_reg[7:4] == smr_pkg::DEV_TYPE);
  wire logic       rwBit     = shiftIn_reg[0];
  wire logic       byteIn    = sclFall & (bitCnt_reg == smr_pkg::BITS_LAST);
  wire logic       byteOut   = sclFall & (bitCnt_reg == smr_pkg::SEND_LAST);
  wire logic [smr_pkg::ADDR_W-1:0] rdStart = {shiftIn_reg[3:1], addr_reg[7:0]};
  wire logic [smr_pkg::ADDR_W-1:0] addrInc = addr_reg + 11'h001;
  wire logic [7:0] rowByte = rowData[{fetchSel_reg, 3'h0} +: 8];

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg    <= smr_pkg::SMR_IDLE;
      bitCnt_reg   <= smr_pkg::CNT_RESET;
      shiftIn_reg  <= smr_pkg::BYTE_RESET;
      shiftOut_reg <= smr_pkg::BYTE_RESET;
      addr_reg     <= smr_pkg::ADDR_RESET;
      drvLow_reg   <= 1'b0;
      ackSeen_reg  <= 1'b0;
      fetch_reg    <= 1'b0;
    end else if (clkEn) begin
      fetch_reg <= 1'b0;
      if (stopEv) begin
        state_reg  <= smr_pkg::SMR_IDLE;
        drvLow_reg <= 1'b0;
      end else if (startEv) begin
        state_reg  <= smr_pkg::SMR_ADDR;
        bitCnt_reg <= smr_pkg::CNT_RESET;
        drvLow_reg <= 1'b0;
      end else begin
        case (state_reg)
          smr_pkg::SMR_ADDR, smr_pkg::SMR_WADDR: begin
            if (sclRise) begin
              shiftIn_reg <= nextIn;
              bitCnt_reg  <= bitCnt_reg + 4'h1;
            end else if (byteIn && state_reg == smr_pkg::SMR_WADDR) begin
              addr_reg   <= {addr_reg[10:8], shiftIn_reg};
              state_reg  <= smr_pkg::SMR_WADDR_ACK;
              drvLow_reg <= 1'b1;
            end else if (byteIn && addrMatch) begin
              state_reg  <= smr_pkg::SMR_ADDR_ACK;
              drvLow_reg <= 1'b1;
              if (rwBit) begin
                addr_reg  <= rdStart;
                fetch_reg <= 1'b1;
              end else begin
                addr_reg  <= {shiftIn_reg[3:1], addr_reg[7:0]};
              end
            end else if (byteIn) begin
              state_reg <= smr_pkg::SMR_IDLE;
            end
          end
          smr_pkg::SMR_ADDR_ACK: begin
            if (sclFall) begin
              bitCnt_reg <= smr_pkg::CNT_RESET;
              if (rwBit) begin
                state_reg    <= smr_pkg::SMR_SEND;
                shiftOut_reg <= byte_reg;
                drvLow_reg   <= ~byte_reg[7];
              end else begin
                state_reg  <= smr_pkg::SMR_WADDR;
                drvLow_reg <= 1'b0;
              end
            end
          end
          smr_pkg::SMR_WADDR_ACK: begin
            // Data bytes of a write belong to the write path and are not taken here
            if (sclFall) begin
              state_reg  <= smr_pkg::SMR_IGNORE;
              drvLow_reg <= 1'b0;
            end
          end
          smr_pkg::SMR_SEND: begin
            if (byteOut) begin
              state_reg  <= smr_pkg::SMR_SEND_ACK;
              drvLow_reg <= 1'b0;
              addr_reg   <= addrInc;
              fetch_reg  <= 1'b1;
            end else if (sclFall) begin
              shiftOut_reg <= {shiftOut_reg[6:0], 1'b0};
              drvLow_reg   <= ~shiftOut_reg[6];
              bitCnt_reg   <= bitCnt_reg + 4'h1;
            end
          end
          smr_pkg::SMR_SEND_ACK: begin
            if (sclRise) begin
              ackSeen_reg <= ~syncB_reg.sda;
            end else if (sclFall && ackSeen_reg) begin
              // Master acked and no STOP came in the slot: drive the next byte
              state_reg    <= smr_pkg::SMR_SEND;
              bitCnt_reg   <= smr_pkg::CNT_RESET;
              shiftOut_reg <= byte_reg;
              drvLow_reg   <= ~byte_reg[7];
            end else if (sclFall) begin
              state_reg <= smr_pkg::SMR_IDLE;
            end
          end
          smr_pkg::SMR_IDLE, smr_pkg::SMR_IGNORE: begin
            drvLow_reg <= 1'b0;
          end
          default: begin
            state_reg  <= smr_pkg::SMR_IDLE;
            drvLow_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Row fetch: a whole row is read, then the addressed byte is kept

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      byte_reg     <= smr_pkg::BYTE_RESET;
      fetchDly_reg <= 1'b0;
      fetchSel_reg <= 3'h0;
    end else if (clkEn) begin
      fetchDly_reg <= fetch_reg;
      if (fetch_reg) begin
        fetchSel_reg <= addr_reg[2:0];
      end
      if (fetchDly_reg) begin
        byte_reg <= rowByte;
      end
    end
  end

  // Row data must be valid the cycle after the request; SCL low time leaves ample slack
  assign rowRdReq = fetch_reg & clkEn;
  assign rowIdx   = addr_reg[10:3];
  assign sdaOut   = 1'b0;
  assign sdaOe    = drvLow_reg;
  assign busy     = (state_reg != smr_pkg::SMR_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst || !clkEn);

  AST_RD_START: assert property (
    state_reg == smr_pkg::SMR_ADDR && byteIn && addrMatch && rwBit && !startEv && !stopEv
    |=> addr_reg == {$past(shiftIn_reg[3:1]), $past(addr_reg[7:0])} && rowRdReq)
    else $error("read start address not formed from page and latch");

  AST_FIRST_BIT: assert property (
    state_reg == smr_pkg::SMR_ADDR_ACK && sclFall && rwBit && !startEv && !stopEv
    |=> state_reg == smr_pkg::SMR_SEND && sdaOe == !$past(byte_reg[7]))
    else $error("first read bit not driven after address acknowledge");

  AST_INC: assert property (
    state_reg == smr_pkg::SMR_SEND && byteOut && !startEv && !stopEv
    |=> addr_reg == $past(addrInc) && state_reg == smr_pkg::SMR_SEND_ACK)
    else $error("address not stepped before acknowledge slot");

  AST_WRAP: assert property (
    state_reg == smr_pkg::SMR_SEND && byteOut && addr_reg == 11'h7FF && !startEv && !stopEv
    |=> addr_reg == 11'h000)
    else $error("address did not wrap to zero");

  AST_ACK_RELEASE: assert property (
    state_reg == smr_pkg::SMR_SEND_ACK |-> !sdaOe)
    else $error("data line held during acknowledge clock");

  AST_ACK_NEXT: assert property (
    state_reg == smr_pkg::SMR_SEND_ACK && sclFall && ackSeen_reg && !startEv && !stopEv
    |=> state_reg == smr_pkg::SMR_SEND && shiftOut_reg == $past(byte_reg))
    else $error("next byte not sent after acknowledge");

  AST_NACK_END: assert property (
    state_reg == smr_pkg::SMR_SEND_ACK && sclFall && !ackSeen_reg && !startEv && !stopEv
    |=> state_reg == smr_pkg::SMR_IDLE ##1 !sdaOe)
    else $error("read not ended after missing acknowledge");

  AST_MSB: assert property (
    state_reg == smr_pkg::SMR_SEND && $past(state_reg) == smr_pkg::SMR_SEND
    && $past(sclFall) |-> sdaOe == !shiftOut_reg[7])
    else $error("data line does not follow byte msb first");

  AST_STOP_ABORT: assert property (
    stopEv |=> state_reg == smr_pkg::SMR_IDLE && !sdaOe)
    else $error("stop did not abort the operation");

  AST_START_ABORT: assert property (
    startEv && !stopEv |=> state_reg == smr_pkg::SMR_ADDR && !sdaOe && bitCnt_reg == 4'h0)
    else $error("start did not restart address reception");

  AST_WADDR_LOAD: assert property (
    state_reg == smr_pkg::SMR_WADDR && byteIn && !startEv && !stopEv
    |=> addr_reg[7:0] == $past(shiftIn_reg) && sdaOe)
    else $error("word address not loaded into latch");

  AST_ROW: assert property (
    fetchDly_reg |-> fetchSel_reg == $past(addr_reg[2:0]))
    else $error("row byte select not taken from fetched address");

  COV_SEQ_READ: cover property (
    state_reg == smr_pkg::SMR_SEND_ACK && sclFall && ackSeen_reg);
  COV_NACK_END: cover property (
    state_reg == smr_pkg::SMR_SEND_ACK && sclFall && !ackSeen_reg);
  COV_SELECTIVE: cover property (
    state_reg == smr_pkg::SMR_IGNORE && startEv);
  COV_WRAP: cover property (
    state_reg == smr_pkg::SMR_SEND && byteOut && addr_reg == 11'h7FF);

endmodule : smr_read_path

// ===== dv/smr_master_model.sv
`timescale 1ns/100ps
module smr_master_model (
  output logic      sclLine,
  output wire logic sdaLine,
  input  wire logic devOe
);
  logic mOe = 1'b0;
  // Pull-up: a released line reads high, never a stale value
  assign sdaLine = !(mOe || devOe);
  initial sclLine = 1'b1;
  ////////////////////////////////////////
  // Low 20 ns, high 12 ns: the lines are sampled 11 ns after the rise
  task automatic bitOut(input logic b, output logic [1:0] r);
    #4 mOe = !b;
    #16 sclLine = 1'b1;
    #11 r = {devOe, sdaLine};
    #1 sclLine = 1'b0;
  endtask : bitOut
  // A START leaves SCL low; a STOP leaves the bus idle and still
  task automatic cond(input logic isStop);
    #4 mOe = isStop;
    #16 sclLine = 1'b1;
    #6 mOe = !isStop;
    #6 sclLine = isStop;
  endtask : cond
  task automatic sendByte(input logic [7:0] v, output logic nak);
    logic [1:0] r;
    for (int i = 7; i >= 0; i--) bitOut(v[i], r);
    bitOut(1'b1, r);
    nak = r[0];
  endtask : sendByte
  task automatic recvByte(output logic [7:0] v);
    logic [1:0] r;
    for (int i = 7; i >= 0; i--) begin
      bitOut(1'b1, r);
      v[i] = r[0];
    end
  endtask : recvByte
endmodule : smr_master_model

// ===== dv/serial_memory_read_path_bench.sv
`timescale 1ns/100ps
module serial_memory_read_path_bench;
  logic        ref_clk    = 1'b0;
  logic        sys_rst    = 1'b1;
  logic        scl;
  logic        sda;
  logic        sdaOe;
  logic        rowRdReq;
  logic        busy;
  logic [7:0]  rowIdx;
  logic [63:0] rowData    = 64'h0;
  logic [31:0] rng        = 32'h32C1701B;
  logic [10:0] expAddr    = 11'h000;
  int          fails      = 0;
  int          num_checks = 0;
  int          cyc        = 0;

  always #2 ref_clk = !ref_clk;

  smr_read_path DUT (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .clkEn    (1'b1),
    .sclIn    (scl),
    .sdaIn    (sda),
    .sdaOut   (),
    .sdaOe    (sdaOe),
    .rowRdReq (rowRdReq),
    .rowIdx   (rowIdx),
    .rowData  (rowData),
    .busy     (busy)
  );
  smr_master_model MST (
    .sclLine (scl),
    .sdaLine (sda),
    .devOe   (sdaOe)
  );
  ////////////////////////////////////////
  function automatic logic [7:0] memByte(input logic [10:0] a);
    return (a[7:0] * 8'h1D) ^ {5'h05, a[10:8]};
  endfunction : memByte
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // Row array answers one cycle after the request
  always @(posedge ref_clk) begin
    if (rowRdReq === 1'b1) begin
      for (int k = 0; k < 8; k++) rowData[8*k +: 8] <= memByte({rowIdx, 3'(k)});
    end
  end
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic seek(input logic [10:0] a);
    logic nak;
    MST.cond(1'b0);
    MST.sendByte({4'hA, a[10:8], 1'b0}, nak);
    chk(8'(nak), 8'h00, "write address ack");
    MST.sendByte(a[7:0], nak);
    chk(8'(nak), 8'h00, "word address ack");
    expAddr = a;
  endtask : seek
  // Way: 0 nack+STOP, 1 nack+START, 2 STOP in ack slot, 3 START in ack slot
  task automatic readRun(input logic [2:0] pg, input int n, input logic [1:0] way);
    logic [7:0] v;
    logic [1:0] r;
    logic       nak;
    MST.cond(1'b0);
    MST.sendByte({4'hA, pg, 1'b1}, nak);
    chk(8'(nak), 8'h00, "read address ack");
    expAddr[10:8] = pg;
    for (int i = 0; i < n; i++) begin
      if (i > 0) begin
        MST.bitOut(1'b0, r);
        chk(8'(r[1]), 8'h00, "ack slot driven");
      end
      MST.recvByte(v);
      chk(v, memByte(expAddr), "read data");
      expAddr = expAddr + 11'h001;
    end
    if (way < 2'd2) begin
      MST.bitOut(1'b1, r);
      chk(8'(r), 8'h01, "nack slot line");
    end
    MST.cond(!way[0]);
    if (!way[0]) begin
      #20;
      chk(8'({busy, sdaOe}), 8'h00, "idle after stop");
    end
  endtask : readRun
  // Foreign device type, then a word address cut short by STOP
  task automatic oddOps(input logic [7:0] part);
    logic       nak;
    logic [1:0] r;
    MST.cond(1'b0);
    MST.sendByte({4'h5, part[2:0], 1'b1}, nak);
    chk(8'(nak), 8'h01, "foreign type ack");
    MST.cond(1'b0);
    MST.sendByte({4'hA, part[6:4], 1'b0}, nak);
    for (int i = 7; i > 3; i--) MST.bitOut(part[i], r);
    MST.cond(1'b1);
    #20;
    chk(8'({busy, sdaOe}), 8'h00, "idle after abort");
  endtask : oddOps
  task automatic summarize();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  ////////////////////////////////////////
  // Ceiling about twice the expected run length
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    #40;
    readRun(3'h0, 3, 2'd0);
    readRun(3'h5, 2, 2'd1);
    seek(11'h7FE);
    readRun(3'h7, 3, 2'd3);
    for (int t = 0; t < 40; t++) begin
      rng = xs(rng);
      oddOps(rng[31:24]);
      seek(rng[10:0]);
      readRun(rng[18:16], int'(rng[13:12]) + 1, rng[15:14]);
    end
    MST.cond(1'b1);
    summarize();
  end
endmodule : serial_memory_read_path_bench
